// ### design/spef_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// (R01) four serial clock timings chosen by polarity and phase bits
// (R02) polarity xor phase picks the capture edge; both ends must match
// (R03) software disables the unit before changing polarity between bytes
// (R04) select low while master sets mode fault, interrupt if enabled
// (R05) mode fault clears the enable bit, releasing all outputs
// (R06) mode fault clears the master bit, falling back to slave
// (R07) mode fault clears after status read while set, then control write
// (R08) select held high during clearing; enable and master restorable then
// (R09) while mode fault set, enable and master cannot be set outside clearing
// (R10) slave never newly sets mode fault; an old one may stay
// (R11) byte completing with transfer flag still set raises overrun
// (R12) on overrun the buffer keeps the first byte; later ones dropped
// (R13) overrun clears on a status register read
// (R14) data write during transfer is dropped, transfer goes on, collision set
// (R15) collision flag never requests an interrupt; cleared by software sequence
// (R16) received byte goes to a cpu synchronous buffer; reads never collide
// (R17) in wait the unit runs normally and enabled events wake the cpu
// (R18) in halt registers freeze; several bytes before wake give overrun; code stops only the master engine, flags and buffer still update
// (R19) slave end of transfer wakes from halt; fault and overrun do not
// (R20) select must be low on halt entry for wake to work
// (R21) after halt wake in slave mode run one extra transfer
// (R22) one interrupt line, gated by enable bit and cpu interrupt mask
// (R23) transfer flag sets at byte end; clears after status then data access
// (R24) software manage bit substitutes the level bit for the select pin
module spef_top (
   input wire logic clk_i,                          // cpu clock
   input wire logic nrst_i,                         // async reset, active low
   input wire logic ce_i,                           // clock enable, freezes cpu clock state
   input wire logic sck_i,                          // serial clock pin in, slave domain
   input wire logic ss_n_i,                         // slave select pin
   input wire logic mosi_i,                         // master out pin, as input
   input wire logic miso_i,                         // master in pin, as input
   input wire logic cr_wr_i,                        // control register write strobe
   input wire spef_pkg::spef_ctrl_t cr_wdata_i,     // control write data
   input wire logic csr_rd_i,                       // status register read strobe
   input wire logic csr_wr_i,                       // status register write strobe
   input wire spef_pkg::spef_sel_t csr_wdata_i,     // status write data
   input wire logic dr_rd_i,                        // data register read strobe
   input wire logic dr_wr_i,                        // data register write strobe
   input wire logic [7:0] dr_wdata_i,               // data write byte
   input wire logic imask_i,                        // cpu interrupt mask, high masks
   input wire logic halt_i,                         // cpu in halt
   output spef_pkg::spef_ctrl_t ctrl_o,             // control register readback
   output spef_pkg::spef_sel_t sel_o,               // select bits readback
   output spef_pkg::spef_flags_t flags_o,           // status flags
   output logic [7:0] rx_data_o,                    // receive buffer
   output logic irq_o,                              // interrupt request
   output logic wake_o,                             // halt wake request
   output logic sck_o,                              // serial clock out
   output logic sck_oe_n_o,                         // serial clock drive, low drives
   output logic mosi_o,                             // master data out
   output logic mosi_oe_n_o,                        // master data drive, low drives
   output logic miso_o,                             // slave data out
   output logic miso_oe_n_o                         // slave data drive, low drives
);
   spef_pkg::spef_ctrl_t ctrl_q;
   spef_pkg::spef_sel_t sel_q;
   spef_pkg::spef_flags_t flags_q;
   spef_pkg::spef_mst_t mst_q;
   logic [7:0] rx_q;
   logic [7:0] tx_q;
   logic [1:0] ss_sync_q;
   logic [1:0] miso_sync_q;
   logic [1:0] tgl_sync_q;
   logic tgl_prev_q;
   logic done_arm_q;
   logic write_collision_flag_arm_q;
   logic mode_fault_flag_arm_q;
   logic [7:0] half_q;
   logic [4:0] edge_q;
   logic [7:0] msh_q;
   logic [7:0] mrx_q;
   logic sck_q;
   logic mosi_q;
   logic sck_oe_n_q;
   logic mosi_oe_n_q;
   logic miso_oe_n_q;
   logic irq_q;
   logic wake_q;
   // slave domain state
   logic [2:0] scnt_q;
   logic [6:0] srx_q;
   logic [7:0] sbyte_q;
   logic stgl_q;
   logic smiso_q;

   logic ss_int;
   logic ss_raw;
   logic sck_cap;
   logic srst_n;
   logic m_busy;
   logic busy;
   logic m_done;
   logic s_done;
   logic done_ev;
   logic [7:0] done_byte;
   logic done_clr;
   logic write_collision_flag_clr;
   logic mode_fault_flag_clr;
   logic mode_fault_flag_set;
   logic dr_take;
   logic write_collision_flag_set;
   logic half_end;
   logic lead_edge;
   logic cap_edge;

   // synchronisers for pins and the slave completion toggle
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ss_sync_q <= 2'h3;
         miso_sync_q <= 2'h0;
         tgl_sync_q <= 2'h0;
         tgl_prev_q <= 1'b0;
      end else if (ce_i) begin
         ss_sync_q <= {ss_sync_q[0], ss_n_i};
         miso_sync_q <= {miso_sync_q[0], miso_i};
         tgl_sync_q <= {tgl_sync_q[0], stgl_q};
         tgl_prev_q <= tgl_sync_q[1];
      end
   end

   assign ss_int = sel_q.select_software_manage_bit ? sel_q.select_software_level_bit : ss_sync_q[1];  // R24
   assign m_busy = (mst_q != spef_pkg::MST_IDLE);
   // a selected slave counts as mid transfer
   assign busy = m_busy | (~ctrl_q.master_select_bit & ctrl_q.en & ~ss_int);
   assign s_done = (tgl_sync_q[1] ^ tgl_prev_q) & ~ctrl_q.master_select_bit;
   assign m_done = (mst_q == spef_pkg::MST_DONE);
   assign done_ev = s_done | m_done;  // R23
   assign done_byte = m_done ? mrx_q : sbyte_q;
   assign mode_fault_flag_set = ctrl_q.master_select_bit & ~ss_int;  // R04 R10
   assign done_clr = done_arm_q & (dr_rd_i | dr_wr_i);  // R23
   assign write_collision_flag_clr = write_collision_flag_arm_q & (dr_rd_i | dr_wr_i);  // R15
   assign mode_fault_flag_clr = mode_fault_flag_arm_q & cr_wr_i;  // R07
   assign write_collision_flag_set = dr_wr_i & busy;  // R14
   // writes wait for a status access while the transfer flag stands
   assign dr_take = dr_wr_i & ~busy & ~(flags_q.done & ~done_arm_q);

   // control and select registers
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_q <= spef_pkg::CTRL_RESET;
         sel_q <= spef_pkg::SEL_RESET;
      end else if (ce_i) begin
         if (csr_wr_i) begin
            sel_q <= csr_wdata_i;
         end
         if (mode_fault_flag_set) begin
            ctrl_q.en <= 1'b0;  // R05
            ctrl_q.master_select_bit <= 1'b0;  // R06
         end else if (cr_wr_i) begin
            ctrl_q.ie <= cr_wdata_i.ie;
            ctrl_q.clock_polarity_bit <= cr_wdata_i.clock_polarity_bit;  // R01 R03
            ctrl_q.clock_phase_bit <= cr_wdata_i.clock_phase_bit;  // R01
            if (flags_q.mode_fault_flag && !mode_fault_flag_clr) begin
               ctrl_q.en <= ctrl_q.en & cr_wdata_i.en;  // R09
               ctrl_q.master_select_bit <= ctrl_q.master_select_bit & cr_wdata_i.master_select_bit;  // R09
            end else begin
               ctrl_q.en <= cr_wdata_i.en;  // R08
               ctrl_q.master_select_bit <= cr_wdata_i.master_select_bit;
            end
         end
      end
   end

   // clearing sequence arming: a status access while the flag stands, only a status read for mode fault
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         done_arm_q <= 1'b0;
         write_collision_flag_arm_q <= 1'b0;
         mode_fault_flag_arm_q <= 1'b0;
      end else if (ce_i) begin
         if (done_clr || done_ev) begin
            done_arm_q <= 1'b0;
         end else if ((csr_rd_i || csr_wr_i) && flags_q.done) begin
            done_arm_q <= 1'b1;  // R23
         end
         if (write_collision_flag_clr || write_collision_flag_set) begin
            write_collision_flag_arm_q <= 1'b0;
         end else if ((csr_rd_i || csr_wr_i) && flags_q.write_collision_flag) begin
            write_collision_flag_arm_q <= 1'b1;
         end
         if (mode_fault_flag_clr || mode_fault_flag_set) begin
            mode_fault_flag_arm_q <= 1'b0;
         end else if (csr_rd_i && flags_q.mode_fault_flag) begin
            mode_fault_flag_arm_q <= 1'b1;  // R07
         end
      end
   end

   // status flags; a setting event wins over a clear in the same cycle
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flags_q <= spef_pkg::FLAGS_RESET;
      end else if (ce_i) begin
         if (done_ev) begin
            flags_q.done <= 1'b1;  // R23
         end else if (done_clr) begin
            flags_q.done <= 1'b0;
         end
         if (write_collision_flag_set) begin
            flags_q.write_collision_flag <= 1'b1;  // R14
         end else if (write_collision_flag_clr) begin
            flags_q.write_collision_flag <= 1'b0;
         end
         if (done_ev && flags_q.done && !done_clr) begin
            flags_q.overrun_flag <= 1'b1;  // R11 R18
         end else if (csr_rd_i) begin
            flags_q.overrun_flag <= 1'b0;  // R13
         end
         if (mode_fault_flag_set) begin
            flags_q.mode_fault_flag <= 1'b1;  // R04
         end else if (mode_fault_flag_clr) begin
            flags_q.mode_fault_flag <= 1'b0;  // R07
         end
      end
   end

   // receive buffer, read by the cpu in its own clock
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_q <= spef_pkg::RX_RESET;
      end else if (ce_i) begin
         if (done_ev && !(flags_q.done && !done_clr)) begin
            rx_q <= done_byte;  // R12 R16
         end
      end
   end

   // transmit byte; refused writes leave it untouched
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_q <= spef_pkg::RX_RESET;
      end else if (ce_i) begin
         if (dr_take) begin
            tx_q <= dr_wdata_i;  // R14
         end
      end
   end

   // master engine: clock divided from the cpu clock, stopped in halt
   assign half_end = (half_q == spef_pkg::HALF_CNT_LAST);
   assign lead_edge = ~edge_q[0];
   assign cap_edge = lead_edge ^ ctrl_q.clock_phase_bit;  // R02

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mst_q <= spef_pkg::MST_IDLE;
         half_q <= 8'h00;
         edge_q <= 5'h00;
         msh_q <= 8'h00;
         mrx_q <= 8'h00;
         sck_q <= 1'b0;
         mosi_q <= 1'b0;
      end else if (ce_i && !halt_i) begin  // R18
         case (mst_q)
            spef_pkg::MST_IDLE: begin
               sck_q <= ctrl_q.clock_polarity_bit;  // R01
               half_q <= 8'h00;
               edge_q <= 5'h00;
               if (dr_take && ctrl_q.master_select_bit && ctrl_q.en) begin
                  msh_q <= dr_wdata_i;
                  mosi_q <= dr_wdata_i[7];
                  mst_q <= spef_pkg::MST_RUN;
               end
            end
            spef_pkg::MST_RUN: begin
               if (!ctrl_q.master_select_bit || !ctrl_q.en) begin
                  mst_q <= spef_pkg::MST_IDLE;  // R05
               end else if (half_end) begin
                  half_q <= 8'h00;
                  sck_q <= ~sck_q;
                  edge_q <= edge_q + 5'h01;
                  if (cap_edge) begin
                     mrx_q <= {mrx_q[6:0], miso_sync_q[1]};  // R02
                  end else begin
                     mosi_q <= ctrl_q.clock_phase_bit ? msh_q[7] : msh_q[6];
                     msh_q <= {msh_q[6:0], 1'b0};
                  end
                  if (edge_q == spef_pkg::EDGE_LAST) begin
                     mst_q <= spef_pkg::MST_DONE;
                  end
               end else begin
                  half_q <= half_q + 8'h01;
               end
            end
            spef_pkg::MST_DONE: begin
               mst_q <= spef_pkg::MST_IDLE;
            end
            default: begin
               mst_q <= spef_pkg::MST_IDLE;
            end
         endcase
      end
   end

   // pin drive enables; nothing driven while disabled
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sck_oe_n_q <= 1'b1;
         mosi_oe_n_q <= 1'b1;
         miso_oe_n_q <= 1'b1;
      end else if (ce_i) begin
         sck_oe_n_q <= ~(ctrl_q.en & ctrl_q.master_select_bit);  // R05
         mosi_oe_n_q <= ~(ctrl_q.en & ctrl_q.master_select_bit & ~sel_q.sod);
         miso_oe_n_q <= ~(ctrl_q.en & ~ctrl_q.master_select_bit & ~sel_q.sod & ~ss_int);
      end
   end

   // single request line, also the wait exit; halt wake only on slave completion
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_q <= 1'b0;
         wake_q <= 1'b0;
      end else if (ce_i) begin
         irq_q <= ctrl_q.ie & ~imask_i & (flags_q.done | flags_q.overrun_flag | flags_q.mode_fault_flag);  // R22 R15 R17
         wake_q <= halt_i & ctrl_q.ie & ~ctrl_q.master_select_bit & flags_q.done;  // R19
      end
   end

   // slave domain: capture on sck xor polarity xor phase, held in reset
   // while deselected, so the select line ends each frame
   assign sck_cap = sck_i ^ ctrl_q.clock_polarity_bit ^ ctrl_q.clock_phase_bit;  // R02
   assign ss_raw = sel_q.select_software_manage_bit ? sel_q.select_software_level_bit : ss_n_i;  // R24 R20
   assign srst_n = nrst_i & ~ss_raw & ctrl_q.en & ~ctrl_q.master_select_bit;

   always_ff @(posedge sck_cap or negedge srst_n) begin
      if (!srst_n) begin
         scnt_q <= 3'h0;
         srx_q <= 7'h00;
      end else begin
         scnt_q <= scnt_q + 3'h1;
         srx_q <= {srx_q[5:0], mosi_i};
      end
   end

   // completed byte and its toggle survive deselection
   always_ff @(posedge sck_cap or negedge nrst_i) begin
      if (!nrst_i) begin
         sbyte_q <= spef_pkg::RX_RESET;
         stgl_q <= 1'b0;
      end else if (srst_n && scnt_q == spef_pkg::BIT_LAST) begin
         sbyte_q <= {srx_q, mosi_i};
         stgl_q <= ~stgl_q;
      end
   end

   // launch edge; tx_q is stable because writes are refused while selected
   always_ff @(negedge sck_cap or negedge srst_n) begin
      if (!srst_n) begin
         smiso_q <= 1'b0;
      end else begin
         smiso_q <= tx_q[~scnt_q];
      end
   end

   assign ctrl_o = ctrl_q;
   assign sel_o = sel_q;
   assign flags_o = flags_q;
   assign rx_data_o = rx_q;
   assign irq_o = irq_q;
   assign wake_o = wake_q;
   assign sck_o = sck_q;
   assign sck_oe_n_o = sck_oe_n_q;
   assign mosi_o = mosi_q;
   assign mosi_oe_n_o = mosi_oe_n_q;
   assign miso_o = smiso_q;
   assign miso_oe_n_o = miso_oe_n_q;
endmodule : spef_top

// ### design/spef_pkg.sv
package spef_pkg;
   // cpu clock and the master serial clock half period
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned SCK_HALF_NS = 40;
   localparam int unsigned SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] HALF_CNT_LAST = 8'(SCK_HALF_CYC - 1);
   // sixteen clock edges make one byte
   localparam logic [4:0] EDGE_LAST = 5'h0F;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [7:0] RX_RESET = 8'h00;
   // field positions inside the packed carriers
   localparam int unsigned CTRL_IE_POS = 4;
   localparam int unsigned CTRL_EN_POS = 3;
   localparam int unsigned CTRL_MASTER_SELECT_BIT_POS = 2;
   localparam int unsigned FLAG_DONE_POS = 3;

   typedef struct packed {
      logic ie;    // interrupt_enable_bit
      logic en;    // peripheral_enable_bit
      logic master_select_bit;  // master_select_bit
      logic clock_polarity_bit;  // clock_polarity_bit
      logic clock_phase_bit;  // clock_phase_bit
   } spef_ctrl_t;

   typedef struct packed {
      logic sod;   // serial output disable
      logic select_software_manage_bit;   // select_software_manage_bit
      logic select_software_level_bit;   // select_software_level_bit
   } spef_sel_t;

   typedef struct packed {
      logic done;  // transfer_complete_flag
      logic write_collision_flag;  // write_collision_flag
      logic overrun_flag;   // overrun_flag
      logic mode_fault_flag;  // mode_fault_flag
   } spef_flags_t;

   localparam spef_ctrl_t CTRL_RESET = '0;
   localparam spef_sel_t SEL_RESET = '0;
   localparam spef_flags_t FLAGS_RESET = '0;

   typedef enum logic [1:0] {
      MST_IDLE = 2'b00,
      MST_RUN = 2'b01,
      MST_DONE = 2'b10
   } spef_mst_t;
endpackage : spef_pkg

// ### tb/spef_chk_properties.sv
`timescale 1ns/1ns
module spef_chk (
   input wire logic clk_i, // cpu clock
   input wire logic nrst_i, // reset, active low
   input wire logic ce_i, // clock enable
   input wire logic cr_wr_i, // control write
   input wire logic csr_rd_i, // status read
   input wire logic dr_rd_i, // data read
   input wire logic dr_wr_i, // data write
   input wire logic imask_i, // cpu mask
   input wire logic halt_i, // cpu halt
   input wire spef_pkg::spef_ctrl_t ctrl_o, // control
   input wire spef_pkg::spef_sel_t sel_o, // select bits
   input wire spef_pkg::spef_flags_t flags_o, // flags
   input wire logic [7:0] rx_data_o, // receive buffer
   input wire logic irq_o, // interrupt
   input wire logic wake_o // wake request
);
   logic armed_q;
   logic any_ev;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // fault clearing armed by a status read while the fault stands
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         armed_q <= 1'b0;
      end else if (ce_i && cr_wr_i) begin
         armed_q <= 1'b0;
      end else if (ce_i && csr_rd_i && flags_o.mode_fault_flag) begin
         armed_q <= 1'b1;
      end
   end
   assign any_ev = flags_o.done | flags_o.overrun_flag | flags_o.mode_fault_flag;
   property p_fault_set;
      ce_i && ctrl_o.master_select_bit && sel_o.select_software_manage_bit && !sel_o.select_software_level_bit |-> ##[1:3] flags_o.mode_fault_flag;
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault not flagged");
   property p_fault_off; $rose(flags_o.mode_fault_flag) |-> !ctrl_o.en && !ctrl_o.master_select_bit; endproperty
   a_fault_off: assert property (p_fault_off) else $error("fault kept master");
   property p_fault_refuse;
      ce_i && cr_wr_i && flags_o.mode_fault_flag && !armed_q |=> !ctrl_o.en && !ctrl_o.master_select_bit;
   endproperty
   a_fault_refuse: assert property (p_fault_refuse) else $error("enable taken");
   property p_fault_clear; ce_i && cr_wr_i && armed_q |=> !flags_o.mode_fault_flag; endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("fault stuck");
   property p_slave_nofault; !ctrl_o.master_select_bit && !flags_o.mode_fault_flag |=> !flags_o.mode_fault_flag; endproperty
   a_slave_nofault: assert property (p_slave_nofault) else $error("slave fault");
   property p_ovr_cause; $rose(flags_o.overrun_flag) |-> $past(flags_o.done); endproperty
   a_ovr_cause: assert property (p_ovr_cause) else $error("overrun no cause");
   // a clear landing with a new byte lets that byte in as the first one
   property p_ovr_keep;
      flags_o.done && $past(flags_o.done) && !$past(dr_rd_i || dr_wr_i)
         |-> $stable(rx_data_o);
   endproperty
   a_ovr_keep: assert property (p_ovr_keep) else $error("buffer overwritten");
   property p_ovr_clear; ce_i && csr_rd_i |=> !flags_o.overrun_flag; endproperty
   a_ovr_clear: assert property (p_ovr_clear) else $error("overrun kept");
   property p_irq_on; ctrl_o.ie && !imask_i && any_ev |=> irq_o; endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq missing");
   property p_irq_off; !(ctrl_o.ie && !imask_i && any_ev) |=> !irq_o; endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq spurious");
   property p_wake_on;
      halt_i && ctrl_o.ie && !ctrl_o.master_select_bit && flags_o.done |=> wake_o;
   endproperty
   a_wake_on: assert property (p_wake_on) else $error("wake missing");
   property p_wake_off; !(halt_i && flags_o.done) |=> !wake_o; endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake spurious");
endmodule : spef_chk

bind spef_top spef_chk spef_chk_i (.clk_i, .nrst_i, .ce_i, .cr_wr_i, .csr_rd_i, .dr_rd_i,
   .dr_wr_i, .imask_i, .halt_i, .ctrl_o, .sel_o, .flags_o, .rx_data_o, .irq_o, .wake_o);

// ### tb/spef_far_master.sv
`timescale 1ns/1ns
module spef_far_master (
   output logic sck_o, // serial clock
   output logic mosi_o, // data to block
   output logic ss_n_o, // select
   input wire logic miso_i // data from block
);
   logic [7:0] rx_q;
   initial begin
      sck_o = 1'b0;
      mosi_o = 1'b1;
      ss_n_o = 1'b1;
      rx_q = 8'h00;
   end
   // one msb-first byte, 80 ns clock, still outside the frame
   task automatic send_byte(input logic [7:0] tx, input logic clock_polarity_bit, input logic clock_phase_bit);
      sck_o = clock_polarity_bit;
      #33;
      ss_n_o = 1'b0;
      #40;
      for (int i = 7; i >= 0; i--) begin
         if (!clock_phase_bit) mosi_o = tx[i];
         #40 sck_o = ~clock_polarity_bit;
         if (clock_phase_bit) mosi_o = tx[i];
         else rx_q[i] = miso_i;
         #40 sck_o = clock_polarity_bit;
         if (clock_phase_bit) rx_q[i] = miso_i;
      end
      #40;
      ss_n_o = 1'b1;
      mosi_o = ~mosi_o;
   endtask : send_byte
endmodule : spef_far_master

// ### tb/spef_top_tb.sv
`timescale 1ns/1ns
module spef_top_tb;
   logic clk_i;
   logic nrst_i;
   logic sck, ss_n, mosi, miso, cr_wr, csr_rd, csr_wr, dr_rd, dr_wr, imask, halt;
   logic irq, wake, sck_m, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
   logic [7:0] dr_d, rx, b;
   spef_pkg::spef_ctrl_t cr_d, ctrl;
   spef_pkg::spef_sel_t csr_d, sel;
   spef_pkg::spef_flags_t flags;
   int failures = 0;
   int num_checks = 0;
   // master loops its output back, else slave drives, else pulled up
   assign miso = !mosi_oe_n ? mosi_o : (!miso_oe_n ? miso_o : 1'b1);
   spef_top spef_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .sck_i(sck),
      .ss_n_i(ss_n), .mosi_i(mosi), .miso_i(miso), .cr_wr_i(cr_wr), .cr_wdata_i(cr_d),
      .csr_rd_i(csr_rd), .csr_wr_i(csr_wr), .csr_wdata_i(csr_d), .dr_rd_i(dr_rd),
      .dr_wr_i(dr_wr), .dr_wdata_i(dr_d), .imask_i(imask), .halt_i(halt), .ctrl_o(ctrl),
      .sel_o(sel), .flags_o(flags), .rx_data_o(rx), .irq_o(irq), .wake_o(wake),
      .sck_o(sck_m), .sck_oe_n_o(sck_oe_n), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n),
      .miso_o(miso_o), .miso_oe_n_o(miso_oe_n));
   spef_far_master spef_far_master_i (.sck_o(sck), .mosi_o(mosi), .ss_n_o(ss_n),
      .miso_i(miso));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic pulse(ref logic s);
      @(negedge clk_i);
      s = 1'b1;
      @(negedge clk_i);
      s = 1'b0;
   endtask : pulse
   task automatic ctl(input logic ie, en, ms, cp, ch);
      cr_d = '{ie, en, ms, cp, ch};
      pulse(cr_wr);
   endtask : ctl
   task automatic sel_w(input logic select_software_manage_bit, select_software_level_bit);
      csr_d = '{1'b0, select_software_manage_bit, select_software_level_bit};
      pulse(csr_wr);
   endtask : sel_w
   task automatic settle(input int n);
      repeat (n) @(negedge clk_i);
   endtask : settle
   task automatic t_reset;
      check("ctrl", {3'h0, ctrl}, 8'h00);
      check("flags", {4'h0, flags}, 8'h00);
      check("rx", rx, 8'h00);
      check("oe", {5'h0, sck_oe_n, mosi_oe_n, miso_oe_n}, 8'h07);
   endtask : t_reset
   task automatic t_slave;
      for (int m = 0; m < 4; m++) begin
         ctl(1'b1, 1'b0, 1'b0, m[1], m[0]);
         ctl(1'b1, 1'b1, 1'b0, m[1], m[0]);
         dr_d = 8'hC3 ^ 8'(m);
         pulse(dr_wr);
         b = 8'h96 + 8'(m);
         spef_far_master_i.send_byte(b, m[1], m[0]);
         settle(6);
         check("flags", {4'h0, flags}, 8'h08);
         check("rx", rx, b);
         check("irq", {7'h0, irq}, 8'h01);
         if (m[0]) check("slave out", spef_far_master_i.rx_q, dr_d);
         imask = 1'b1;
         settle(2);
         check("irq masked", {7'h0, irq}, 8'h00);
         imask = 1'b0;
         pulse(csr_rd);
         pulse(dr_rd);
         check("flags", {4'h0, flags}, 8'h00);
      end
   endtask : t_slave
   task automatic t_halt;
      ctl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
      ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
      sel_w(1'b1, 1'b0);
      halt = 1'b1;
      spef_far_master_i.send_byte(8'h5A, 1'b1, 1'b1);
      settle(6);
      check("wake", {7'h0, wake}, 8'h01);
      spef_far_master_i.send_byte(8'hA5, 1'b1, 1'b1);
      settle(6);
      check("flags", {4'h0, flags}, 8'h0A);
      check("rx", rx, 8'h5A);
      halt = 1'b0;
      pulse(csr_rd);
      check("flags", {4'h0, flags}, 8'h08);
      pulse(dr_rd);
      dr_d = 8'h11;
      pulse(dr_wr);
      settle(2);
      check("flags", {4'h0, flags}, 8'h04);
      check("irq", {7'h0, irq}, 8'h00);
      pulse(csr_rd);
      pulse(dr_rd);
      check("flags", {4'h0, flags}, 8'h00);
      // one extra slave transfer after the halt wake restores normal state
      spef_far_master_i.send_byte(8'h3C, 1'b1, 1'b1);
      settle(6);
      check("rx", rx, 8'h3C);
      pulse(csr_rd);
      pulse(dr_rd);
      check("flags", {4'h0, flags}, 8'h00);
   endtask : t_halt
   task automatic t_master;
      sel_w(1'b1, 1'b1);
      check("sel", {5'h0, sel}, 8'h03);
      ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      dr_d = 8'h6B;
      pulse(dr_wr);
      settle(10);
      dr_d = 8'hFF;
      pulse(dr_wr);
      for (int i = 0; i < 150 && flags.done !== 1'b1; i++) @(negedge clk_i);
      check("flags", {4'h0, flags}, 8'h0C);
      check("rx", rx, 8'h6B);
      check("sck idle", {7'h0, sck_m}, 8'h00);
      pulse(csr_rd);
      pulse(dr_rd);
   endtask : t_master
   task automatic t_fault;
      sel_w(1'b1, 1'b0);
      settle(2);
      check("flags", {4'h0, flags}, 8'h01);
      check("ctrl", {3'h0, ctrl}, 8'h10);
      check("irq", {7'h0, irq}, 8'h01);
      check("sck oe", {7'h0, sck_oe_n}, 8'h01);
      ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      check("ctrl", {3'h0, ctrl}, 8'h10);
      sel_w(1'b1, 1'b1);
      pulse(csr_rd);
      ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      check("flags", {4'h0, flags}, 8'h00);
      check("ctrl", {3'h0, ctrl}, 8'h1C);
   endtask : t_fault
   task automatic final_report;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      #100000;
      failures++;
      final_report();
   end
   initial begin
      {nrst_i, cr_wr, csr_rd, csr_wr, dr_rd, dr_wr, imask, halt} = '0;
      {dr_d, cr_d, csr_d, b} = '0;
      settle(3);
      nrst_i = 1'b1;
      settle(3);
      t_reset();
      t_slave();
      t_halt();
      t_master();
      t_fault();
      final_report();
   end
endmodule : spef_top_tb
